// >>> core/smsb_pkg.sv
package smsb_pkg;

  // Control table byte addresses of the motion status group.
  localparam logic [7:0] ADDR_TICK  = 8'h78;
  localparam logic [7:0] ADDR_MOVE  = 8'h7a;
  localparam logic [7:0] ADDR_DET   = 8'h7b;
  localparam logic [7:0] ADDR_DUTY  = 8'h7c;
  localparam logic [7:0] ADDR_LOAD  = 8'h7e;
  localparam logic [7:0] ADDR_SPEED = 8'h80;
  localparam logic [7:0] ADDR_ANGLE = 8'h84;
  localparam logic [7:0] ADDR_PSPD  = 8'h88;
  localparam logic [7:0] ADDR_PANG  = 8'h8c;
  localparam logic [7:0] ADDR_VOLT  = 8'h90;
  localparam logic [7:0] ADDR_TEMP  = 8'h92;

  // Motion detail byte layout.
  localparam int DET_SHAPE_HI = 5;
  localparam int DET_SHAPE_LO = 4;
  localparam int DET_FAULT    = 3;
  localparam int DET_ACTIVE   = 1;
  localparam int DET_ARRIVE   = 0;

  // Trajectory shape codes.
  localparam logic [1:0] SHAPE_TRAP = 2'h3;
  localparam logic [1:0] SHAPE_TRI  = 2'h2;
  localparam logic [1:0] SHAPE_RECT = 2'h1;
  localparam logic [1:0] SHAPE_STEP = 2'h0;

  // Control scheme codes on the mode input.
  localparam logic [7:0] MODE_SPEED  = 8'h01;
  localparam logic [7:0] MODE_SINGLE = 8'h03;
  localparam logic [7:0] MODE_MULTI  = 8'h04;
  localparam logic [7:0] MODE_DUTY   = 8'h10;

  // Timestamp and load limits.
  localparam logic [14:0] TICK_MAX  = 15'h7fff;
  localparam logic [14:0] TICK_RST  = 15'h0000;
  localparam logic signed [15:0] LOAD_MAX = 16'sh03e8;
  localparam logic signed [15:0] LOAD_MIN = -16'sh03e8;

  // Millisecond time base.
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_PERIOD_NS  = 1000000;
  localparam int MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

  // Measured angle of one revolution is a 12-bit absolute code.
  localparam int RAW_W = 12;

  typedef enum logic [1:0] {
    PR_IDLE,
    PR_ACCEL,
    PR_CRUISE,
    PR_DECEL
  } smsb_prof_t;

endpackage

// >>> core/smsb_status_bank.sv
`timescale 1ns/10ps
//
// Contract
// - 15-bit millisecond stamp wraps after 32767
// - Motion flag set when speed exceeds limit
// - Active trajectory forces motion flag high
// - Detail bits 5:4 hold shape, reserved zero
// - Detail bit 3 flags tracking fault
// - Detail bit 1 shows trajectory in progress
// - Detail bit 0 shows arrival
// - Arrival when deviation below tolerance
// - Fault and arrival only in angle modes
// - Triangular when cap speed not reached
// - Load clamped to plus/minus 1000 signed
// - Angle tracks full 32-bit signed range
// - Switch to single-turn reloads absolute angle
// - Drive on in single-turn reloads angle
// - After reset angle restarts from absolute
// - Measured angle includes zero offset
// - Speed mode planned speed reaches goal
// - Angle modes integrate speed, zero at end
// - Planned angle produced only in angle modes
// - Shape from speed cap and acceleration
module smsb_status_bank
  import smsb_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // Control table read port
  input  wire logic               rd_en_i,
  input  wire logic [7:0]         rd_addr_i,
  output logic      [7:0]         rd_data_o,
  output logic                    rd_valid_o,
  // Configuration
  input  wire logic [7:0]         op_mode_i,
  input  wire logic               drive_en_i,
  input  wire logic [31:0]        motion_limit_i,
  input  wire logic [31:0]        prof_cap_i,
  input  wire logic [31:0]        prof_accel_i,
  input  wire logic signed [31:0] zero_offset_i,
  input  wire logic [31:0]        fault_limit_i,
  input  wire logic [31:0]        arrive_tol_i,
  // Goals
  input  wire logic               goal_angle_wr_i,
  input  wire logic signed [31:0] goal_angle_i,
  input  wire logic signed [31:0] goal_speed_i,
  // Measurements
  input  wire logic [RAW_W-1:0]   raw_angle_i,
  input  wire logic signed [31:0] speed_meas_i,
  input  wire logic [15:0]        duty_meas_i,
  input  wire logic signed [15:0] load_raw_i,
  input  wire logic [15:0]        volt_i,
  input  wire logic [7:0]         temp_i
);

  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  localparam int DIV_W = $clog2(TICK_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  function automatic logic is_angle(input logic [7:0] m);
    return (m == MODE_SINGLE) || (m == MODE_MULTI);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond time base

  logic [DIV_W-1:0] div_cnt_r;
  logic             tick_r;
  logic [14:0]      stamp_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_cnt_r <= '0;
      tick_r    <= 1'b0;
    end else begin
      tick_r    <= (div_cnt_r == DIV_LAST);
      div_cnt_r <= (div_cnt_r == DIV_LAST) ? '0 : div_cnt_r + 1'b1;
    end
  end

  // Natural 15-bit overflow gives the wrap to zero after the maximum.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stamp_r <= TICK_RST;
    end else if (tick_r) begin
      stamp_r <= stamp_r + 15'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measured angle tracking

  logic [RAW_W-1:0]   raw_prev_r;
  logic [7:0]         mode_prev_r;
  logic               drive_prev_r;
  logic               boot_r;
  logic signed [31:0] accum_r;
  logic signed [31:0] meas_angle_r;
  logic [RAW_W-1:0]   raw_delta;
  logic               reload;

  // Wrapped 12-bit difference is the signed motion since the last cycle.
  assign raw_delta = raw_angle_i - raw_prev_r;
  assign reload = boot_r
    || (op_mode_i == MODE_SINGLE && mode_prev_r != MODE_SINGLE)
    || (op_mode_i == MODE_SINGLE && drive_en_i && !drive_prev_r);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      raw_prev_r   <= '0;
      mode_prev_r  <= 8'h00;
      drive_prev_r <= 1'b0;
      boot_r       <= 1'b1;
      accum_r      <= '0;
    end else begin
      raw_prev_r   <= raw_angle_i;
      mode_prev_r  <= op_mode_i;
      drive_prev_r <= drive_en_i;
      boot_r       <= 1'b0;
      if (reload) begin
        accum_r <= 32'(raw_angle_i);
      end else begin
        // Wraps freely across the whole signed range.
        accum_r <= accum_r + 32'(signed'(raw_delta));
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meas_angle_r <= '0;
    end else begin
      meas_angle_r <= accum_r + zero_offset_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motion profiler

  smsb_prof_t         st_r;
  logic               active_r;
  logic [31:0]        spd_r;
  logic [31:0]        acc_dist_r;
  logic signed [31:0] goal_r;
  logic signed [31:0] plan_angle_r;
  logic signed [31:0] plan_speed_r;
  logic [1:0]         shape_r;
  logic               angle_mode;
  logic signed [31:0] rem;
  logic [31:0]        rem_mag;
  logic signed [31:0] step;
  logic [32:0]        spd_up;
  logic signed [31:0] vel_diff;
  logic signed [31:0] vel_nxt;

  assign angle_mode = is_angle(op_mode_i);
  assign rem        = goal_r - plan_angle_r;
  assign rem_mag    = mag32(rem);
  assign step       = rem[31] ? -$signed(spd_r) : $signed(spd_r);
  assign spd_up     = {1'b0, spd_r} + {1'b0, prof_accel_i};
  assign vel_diff   = goal_speed_i - plan_speed_r;

  // Speed mode ramps by the acceleration; zero acceleration is a step.
  always_comb begin
    if (prof_accel_i == 32'h0000_0000 || mag32(vel_diff) <= prof_accel_i) begin
      vel_nxt = goal_speed_i;
    end else if (vel_diff[31]) begin
      vel_nxt = plan_speed_r - $signed(prof_accel_i);
    end else begin
      vel_nxt = plan_speed_r + $signed(prof_accel_i);
    end
  end

  // A new goal mid-flight keeps the present speed so motion stays smooth.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r         <= PR_IDLE;
      active_r     <= 1'b0;
      spd_r        <= '0;
      acc_dist_r   <= '0;
      goal_r       <= '0;
      plan_angle_r <= '0;
      plan_speed_r <= '0;
      shape_r      <= SHAPE_STEP;
    end else if (!angle_mode) begin
      // Planned angle is frozen outside the angle modes.
      st_r     <= PR_IDLE;
      active_r <= 1'b0;
      spd_r    <= '0;
      if (op_mode_i != MODE_SPEED) begin
        plan_speed_r <= '0;
      end else if (tick_r) begin
        plan_speed_r <= vel_nxt;
      end
    end else if (goal_angle_wr_i) begin
      goal_r     <= goal_angle_i;
      acc_dist_r <= '0;
      if (prof_cap_i == 32'h0000_0000) begin
        shape_r      <= SHAPE_STEP;
        st_r         <= PR_IDLE;
        active_r     <= 1'b0;
        spd_r        <= '0;
        plan_speed_r <= '0;
        plan_angle_r <= goal_angle_i;
      end else begin
        active_r <= 1'b1;
        if (!active_r) begin
          plan_angle_r <= meas_angle_r;
        end
        if (prof_accel_i == 32'h0000_0000) begin
          shape_r <= SHAPE_RECT;
          st_r    <= PR_CRUISE;
          spd_r   <= prof_cap_i;
        end else begin
          shape_r <= SHAPE_TRAP;
          st_r    <= PR_ACCEL;
          if (!active_r) begin
            spd_r <= '0;
          end
        end
      end
    end else if (tick_r && active_r) begin
      if (rem_mag <= spd_r) begin
        plan_angle_r <= goal_r;
        plan_speed_r <= '0;
        spd_r        <= '0;
        active_r     <= 1'b0;
        st_r         <= PR_IDLE;
        // A short move can end while still accelerating, below the cap.
        if (st_r == PR_ACCEL && spd_r < prof_cap_i) begin
          shape_r <= SHAPE_TRI;
        end
      end else begin
        plan_angle_r <= plan_angle_r + step;
        plan_speed_r <= step;
        unique case (st_r)
          PR_ACCEL: begin
            acc_dist_r <= acc_dist_r + spd_r;
            if (rem_mag <= acc_dist_r) begin
              st_r <= PR_DECEL;
              if (spd_r < prof_cap_i) begin
                shape_r <= SHAPE_TRI;
              end
            end else if (spd_up >= {1'b0, prof_cap_i}) begin
              spd_r <= prof_cap_i;
              st_r  <= PR_CRUISE;
            end else begin
              spd_r <= spd_up[31:0];
            end
          end
          PR_CRUISE: begin
            if (prof_accel_i != 32'h0000_0000 && rem_mag <= acc_dist_r) begin
              st_r <= PR_DECEL;
            end
          end
          PR_DECEL: begin
            // Never brake to zero short of the goal.
            spd_r <= (spd_r > prof_accel_i) ? spd_r - prof_accel_i
                                            : prof_accel_i;
          end
          PR_IDLE: begin
            st_r <= PR_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags and captured readings

  logic              motion_r;
  logic [7:0]        detail_r;
  logic [15:0]       duty_r;
  logic signed [15:0] load_r;
  logic [15:0]       volt_r;
  logic [7:0]        temp_r;
  logic signed [31:0] speed_r;
  logic              fault_now;
  logic              arrive_now;

  assign fault_now  = mag32(plan_angle_r - meas_angle_r) > fault_limit_i;
  assign arrive_now = mag32(goal_r - meas_angle_r) < arrive_tol_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      motion_r <= 1'b0;
    end else begin
      motion_r <= active_r
               || (mag32(speed_meas_i) > motion_limit_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      detail_r <= 8'h00;
    end else begin
      detail_r <= 8'h00;
      detail_r[DET_SHAPE_HI:DET_SHAPE_LO] <= shape_r;
      detail_r[DET_FAULT]  <= angle_mode && fault_now;
      detail_r[DET_ACTIVE] <= active_r;
      detail_r[DET_ARRIVE] <= angle_mode && arrive_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      duty_r  <= '0;
      load_r  <= '0;
      volt_r  <= '0;
      temp_r  <= '0;
      speed_r <= '0;
    end else begin
      duty_r  <= duty_meas_i;
      volt_r  <= volt_i;
      temp_r  <= temp_i;
      speed_r <= speed_meas_i;
      if (load_raw_i > LOAD_MAX) begin
        load_r <= LOAD_MAX;
      end else if (load_raw_i < LOAD_MIN) begin
        load_r <= LOAD_MIN;
      end else begin
        load_r <= load_raw_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control table read port, little-endian bytes

  logic [7:0] rd_byte;
  logic [31:0] rd_word;

  always_comb begin
    unique case (rd_addr_i[3:2])
      2'h0:    rd_word = speed_r;
      2'h1:    rd_word = meas_angle_r;
      2'h2:    rd_word = plan_speed_r;
      default: rd_word = plan_angle_r;
    endcase
  end

  always_comb begin
    rd_byte = 8'h00;
    if (rd_addr_i >= ADDR_SPEED && rd_addr_i < ADDR_VOLT) begin
      rd_byte = rd_word[8*rd_addr_i[1:0] +: 8];
    end else begin
      unique case (rd_addr_i)
        ADDR_TICK:         rd_byte = stamp_r[7:0];
        ADDR_TICK + 8'h01: rd_byte = {1'b0, stamp_r[14:8]};
        ADDR_MOVE:         rd_byte = {7'h00, motion_r};
        ADDR_DET:          rd_byte = detail_r;
        ADDR_DUTY:         rd_byte = duty_r[7:0];
        ADDR_DUTY + 8'h01: rd_byte = duty_r[15:8];
        ADDR_LOAD:         rd_byte = load_r[7:0];
        ADDR_LOAD + 8'h01: rd_byte = load_r[15:8];
        ADDR_VOLT:         rd_byte = volt_r[7:0];
        ADDR_VOLT + 8'h01: rd_byte = volt_r[15:8];
        ADDR_TEMP:         rd_byte = temp_r;
        default:           rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= rd_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_stamp_wrap: assert property (
    tick_r && stamp_r == TICK_MAX |=> stamp_r == TICK_RST)
    else $error("timestamp did not wrap to zero");

  chk_stamp_rate: assert property (
    tick_r |=> !tick_r && stamp_r == 15'($past(stamp_r) + 15'h0001))
    else $error("timestamp step or tick spacing wrong");

  chk_motion_speed: assert property (
    !active_r && mag32(speed_meas_i) <= motion_limit_i |=> !motion_r)
    else $error("motion flag set without motion");

  chk_motion_forced: assert property (
    active_r |=> motion_r)
    else $error("motion flag low during trajectory");

  chk_reserved_zero: assert property (
    detail_r[7:6] == 2'h0 && detail_r[2] == 1'b0)
    else $error("reserved detail bits set");

  chk_active_bit: assert property (
    ##1 detail_r[DET_ACTIVE] == $past(active_r))
    else $error("active bit mismatches trajectory");

  chk_mode_gate: assert property (
    !angle_mode |=> !detail_r[DET_FAULT] && !detail_r[DET_ARRIVE])
    else $error("fault or arrival outside angle modes");

  chk_load_range: assert property (
    load_r <= LOAD_MAX && load_r >= LOAD_MIN)
    else $error("load outside limits");

  chk_single_reload: assert property (
    op_mode_i == MODE_SINGLE && mode_prev_r != MODE_SINGLE
    |=> accum_r == 32'($past(raw_angle_i)))
    else $error("angle not reloaded on single-turn entry");

  chk_step_shape: assert property (
    angle_mode && goal_angle_wr_i && prof_cap_i == 32'h0000_0000
    |=> shape_r == SHAPE_STEP && !active_r && plan_angle_r == goal_r)
    else $error("step profile not applied");

  chk_end_zero: assert property (
    angle_mode && active_r ##1 !active_r |-> plan_speed_r == '0)
    else $error("planned speed not cleared at endpoint");

  cov_stamp_wrap: cover property (tick_r && stamp_r == TICK_MAX);
  cov_triangle:   cover property (shape_r == SHAPE_TRI);
  cov_arrive:     cover property (active_r ##1 detail_r[DET_ARRIVE]);
  cov_fault:      cover property (detail_r[DET_FAULT]);

endmodule

// >>> verification/smsb_host_model.sv
`timescale 1ns/10ps
module smsb_host_model (
  // Clock
  input  wire logic       clk_i,
  // Read port of the status bank
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i,
  output logic            rd_en_o,
  output logic      [7:0] rd_addr_o
);
  initial begin
    rd_en_o   = 1'h0;
    rd_addr_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bytes are fetched one at a time, little endian, with an idle cycle between
  // them. The address is inverted once released so a stale one never matches.
  task automatic read_reg(input  logic [7:0]  addr,
                          input  int          nb,
                          output logic [31:0] val,
                          output logic        ok);
    val = 32'h0000_0000;
    ok  = 1'h1;
    for (int i = 0; i < nb; i++) begin
      @(negedge clk_i);
      rd_en_o   = 1'h1;
      rd_addr_o = addr + 8'(i);
      @(negedge clk_i);
      ok            = ok & (rd_valid_i === 1'h1);
      val[8*i +: 8] = rd_data_i;
      rd_en_o       = 1'h0;
      rd_addr_o     = ~rd_addr_o;
    end
  endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import smsb_pkg::*;
;
  localparam int          TC  = 3;
  localparam logic [31:0] ALL = 32'hffff_ffff;

  logic               clk_i          = 1'h0;
  logic               rst_n_i        = 1'h0;
  logic               rd_en_i;
  logic [7:0]         rd_addr_i;
  logic [7:0]         rd_data_o;
  logic               rd_valid_o;
  logic [7:0]         op_mode_i      = MODE_DUTY;
  logic               drive_en_i     = 1'h0;
  logic [31:0]        motion_limit_i = 32'h0000_000a;
  logic [31:0]        prof_cap_i     = 32'h0000_000a;
  logic [31:0]        prof_accel_i   = 32'h0000_0000;
  logic signed [31:0] zero_offset_i  = 32'sh0000_0000;
  logic [31:0]        fault_limit_i  = 32'h0000_0019;
  logic [31:0]        arrive_tol_i   = 32'h0000_0005;
  logic               goal_angle_wr_i = 1'h0;
  logic signed [31:0] goal_angle_i   = 32'sh0000_0000;
  logic signed [31:0] goal_speed_i   = 32'sh0000_0000;
  logic [RAW_W-1:0]   raw_angle_i    = 12'h200;
  logic signed [31:0] speed_meas_i   = 32'sh0000_0000;
  logic [15:0]        duty_meas_i    = 16'h0000;
  logic signed [15:0] load_raw_i     = 16'sh0000;
  logic [15:0]        volt_i         = 16'h0000;
  logic [7:0]         temp_i         = 8'h00;
  int                 fails          = 0;
  int                 check_count    = 0;
  int                 cyc            = 0;

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  smsb_status_bank #(.TICK_CYCLES(TC)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .rd_en_i(rd_en_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .op_mode_i(op_mode_i), .drive_en_i(drive_en_i),
    .motion_limit_i(motion_limit_i), .prof_cap_i(prof_cap_i),
    .prof_accel_i(prof_accel_i), .zero_offset_i(zero_offset_i),
    .fault_limit_i(fault_limit_i), .arrive_tol_i(arrive_tol_i),
    .goal_angle_wr_i(goal_angle_wr_i), .goal_angle_i(goal_angle_i),
    .goal_speed_i(goal_speed_i), .raw_angle_i(raw_angle_i),
    .speed_meas_i(speed_meas_i), .duty_meas_i(duty_meas_i),
    .load_raw_i(load_raw_i), .volt_i(volt_i), .temp_i(temp_i));

  smsb_host_model i_host (
    .clk_i(clk_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
    .rd_en_o(rd_en_i), .rd_addr_o(rd_addr_i));

  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task rd(input logic [7:0] a, input int n, input logic [31:0] m,
          input logic [31:0] e);
    logic [31:0] v;
    logic        ok;
    i_host.read_reg(a, n, v, ok);
    check({31'h0, ok}, 32'h1);
    check(v & m, e);
  endtask

  task goal(input logic [31:0] g);
    @(negedge clk_i);
    goal_angle_i    = g;
    goal_angle_wr_i = 1'h1;
    @(negedge clk_i);
    goal_angle_wr_i = 1'h0;
  endtask

  // Polls the in-progress bit; the bound stops a stuck trajectory.
  task wait_done;
    logic [31:0] v;
    logic        ok;
    int          k;
    k = 0;
    v = 32'h2;
    while (v[1] !== 1'h0 && k < 300) begin
      i_host.read_reg(ADDR_DET, 1, v, ok);
      k++;
    end
    check({31'h0, v[1]}, 32'h0);
  endtask

  task walk(input int n);
    repeat (n) begin
      @(negedge clk_i);
      raw_angle_i = raw_angle_i + 12'h100;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    wt(3);
    rd(ADDR_MOVE, 1, ALL, 32'h0);
    rd(ADDR_DET, 1, ALL, 32'h0);
    rd(8'h70, 1, ALL, 32'h0);
    rd(ADDR_PSPD, 4, ALL, 32'h0);
    rd(ADDR_ANGLE, 4, ALL, 32'h0000_0200);
  endtask

  task ld_case(input logic [15:0] r, input logic [15:0] e);
    @(negedge clk_i);
    load_raw_i = r;
    wt(2);
    rd(ADDR_LOAD, 2, ALL, {16'h0, e});
  endtask

  task t_meas;
    @(negedge clk_i);
    duty_meas_i  = 16'h1234;
    volt_i       = 16'h00b4;
    temp_i       = 8'h2a;
    speed_meas_i = 32'sh1234_5678;
    wt(2);
    rd(ADDR_DUTY, 2, ALL, 32'h0000_1234);
    rd(ADDR_SPEED, 4, ALL, 32'h1234_5678);
    rd(ADDR_VOLT, 2, ALL, 32'h0000_00b4);
    rd(ADDR_TEMP, 1, ALL, 32'h0000_002a);
    ld_case(16'h07d0, 16'h03e8);
    ld_case(16'hf448, 16'hfc18);
    ld_case(16'h03e8, 16'h03e8);
    ld_case(16'hfc17, 16'hfc18);
  endtask

  task fl_case(input logic [31:0] s, input logic [31:0] e);
    @(negedge clk_i);
    speed_meas_i = s;
    wt(2);
    rd(ADDR_MOVE, 1, ALL, e);
  endtask

  task t_flag;
    fl_case(32'h0000_000b, 32'h1);
    fl_case(32'h0000_000a, 32'h0);
    fl_case(32'hffff_fff5, 32'h1);
    fl_case(32'hffff_fff6, 32'h0);
    fl_case(32'h0000_0000, 32'h0);
  endtask

  task t_angle;
    @(negedge clk_i);
    zero_offset_i = 32'sh0000_0005;
    op_mode_i     = MODE_MULTI;
    walk(20);
    wt(3);
    rd(ADDR_ANGLE, 4, ALL, 32'h0000_1605);
    rst_n_i = 1'h0;
    wt(2);
    rst_n_i = 1'h1;
    wt(3);
    rd(ADDR_ANGLE, 4, ALL, 32'h0000_0605);
    walk(20);
    wt(3);
    rd(ADDR_ANGLE, 4, ALL, 32'h0000_1a05);
    op_mode_i = MODE_SINGLE;
    wt(3);
    rd(ADDR_ANGLE, 4, ALL, 32'h0000_0a05);
    walk(16);
    wt(3);
    rd(ADDR_ANGLE, 4, ALL, 32'h0000_1a05);
    drive_en_i = 1'h1;
    wt(3);
    rd(ADDR_ANGLE, 4, ALL, 32'h0000_0a05);
    zero_offset_i = 32'sh0000_0000;
    wt(3);
  endtask

  task t_rect;
    goal(32'h0000_0a64);
    wt(20);
    rd(ADDR_DET, 1, ALL, 32'h0000_001a);
    rd(ADDR_MOVE, 1, ALL, 32'h1);
    wait_done;
    raw_angle_i = 12'ha64;
    wt(3);
    rd(ADDR_DET, 1, ALL, 32'h0000_0011);
    rd(ADDR_MOVE, 1, ALL, 32'h0);
    rd(ADDR_PANG, 4, ALL, 32'h0000_0a64);
    rd(ADDR_PSPD, 4, ALL, 32'h0);
  endtask

  task t_shapes;
    prof_accel_i = 32'h0000_0002;
    goal(32'h0000_0b2c);
    wt(3);
    rd(ADDR_DET, 1, 32'h30, 32'h30);
    wait_done;
    rd(ADDR_PANG, 4, ALL, 32'h0000_0b2c);
    raw_angle_i = 12'hb2c;
    wt(3);
    goal(32'h0000_0b40);
    wait_done;
    rd(ADDR_DET, 1, 32'h30, 32'h20);
    prof_cap_i = 32'h0000_0000;
    goal(32'h0000_0c00);
    wt(3);
    rd(ADDR_DET, 1, 32'h32, 32'h0);
    rd(ADDR_PANG, 4, ALL, 32'h0000_0c00);
    op_mode_i = MODE_DUTY;
    goal(32'h0000_0100);
    wt(3);
    rd(ADDR_PANG, 4, ALL, 32'h0000_0c00);
    rd(ADDR_DET, 1, 32'h09, 32'h0);
  endtask

  task t_speed;
    op_mode_i    = MODE_SPEED;
    prof_accel_i = 32'h0000_000a;
    goal_speed_i = 32'sh0000_0032;
    wt(60);
    rd(ADDR_PSPD, 4, ALL, 32'h0000_0032);
    rd(ADDR_DET, 1, 32'h09, 32'h0);
  endtask

  // High byte is read on both sides of the low byte to reject torn values.
  task rd16(output logic [15:0] v, output int c);
    logic [31:0] h1;
    logic [31:0] h2;
    logic [31:0] l;
    logic        ok;
    do begin
      i_host.read_reg(ADDR_TICK + 8'h01, 1, h1, ok);
      c = cyc;
      i_host.read_reg(ADDR_TICK, 1, l, ok);
      i_host.read_reg(ADDR_TICK + 8'h01, 1, h2, ok);
    end while (h1 !== h2);
    v = {h1[7:0], l[7:0]};
  endtask

  task t_tick;
    logic [15:0] t0;
    logic [15:0] t1;
    logic [15:0] d;
    int          c0;
    int          c1;
    rd16(t0, c0);
    wt((32768 - int'(t0)) * TC + 30);
    rd16(t1, c1);
    d = (t1 - 16'(int'(t0) + (c1 - c0) / TC)) & 16'h7fff;
    check({31'h0, t1 < 16'h0040}, 32'h1);
    check({31'h0, d < 16'h0002 || d == 16'h7fff}, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(6);
    rst_n_i = 1'h1;
    t_reset;
    t_meas;
    t_flag;
    t_angle;
    t_rect;
    t_shapes;
    t_speed;
    t_tick;
    finish_test;
  end

  // The tick wrap dominates the run at about two milliseconds.
  initial begin
    #3_000_000;
    fails++;
    finish_test;
  end
endmodule
